// ===== dv/tpr_fault_src.sv
// fault source model for the external interrupt 0 pin
// assumes the bench calls fall and rise from one process only
`timescale 1ns/1ps
`default_nettype none

module tpr_fault_src (
  input  wire logic sys_clk_i,
  output var  logic ext_irq0_n_o
);
  // ==========================================
  // pin level
  // the line has a pull-up, so the released level is high
  initial ext_irq0_n_o = 1'b1;

  // changes land just after an edge, like any synchronous driver
  task automatic fall();
    @(posedge sys_clk_i);
    ext_irq0_n_o <= 1'b0;
  endtask

  task automatic rise();
    @(posedge sys_clk_i);
    ext_irq0_n_o <= 1'b1;
  endtask
endmodule // tpr_fault_src

`default_nettype wire

// ===== dv/tpr_top_tb.sv
// self-checking bench: random routing, edge flag modes, forced cutoff
// assumes tpr_fault_src drives the interrupt 0 pin; one scenario runs the filter
`timescale 1ns/1ps
`default_nettype none
`include "tpr_regs.svh"

module tpr_top_tb;
  import tpr_pkg::*;
  logic        sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, ext_irq0_req_o, irq_o;
  logic [15:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, r0, r1, md;
  logic [3:0]  tmr_out_i, tmr_drive_mode_i, chan_in_o, dis;
  logic [5:0]  pin_i, pin_tmr_sel_o, pin_tmr_dat_o, es;
  wire         ext_n;
  int          n_fail, checked;

  tpr_top u_tpr_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tmr_out_i(tmr_out_i),
    .tmr_drive_mode_i(tmr_drive_mode_i), .pin_i(pin_i), .ext_irq0_n_i(ext_n),
    .pin_tmr_sel_o(pin_tmr_sel_o), .pin_tmr_dat_o(pin_tmr_dat_o),
    .chan_in_o(chan_in_o), .ext_irq0_req_o(ext_irq0_req_o), .irq_o(irq_o));

  tpr_fault_src u_tpr_fault_src (.sys_clk_i(sys_clk_i), .ext_irq0_n_o(ext_n));

  // ==========================================
  // clock, watchdog, verdict
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    close_out();
  end

  task automatic close_out();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // ==========================================
  // expectations; a channel owns its pin only in an output mode and not disabled
  function automatic logic [5:0] exp_sel(input logic [7:0] a, input logic [7:0] b,
                                         input logic [3:0] d, input logic [3:0] m);
    logic [3:0] on;
    on = m & ~d;
    exp_sel = {b[5:4] == 2'b10 && on[3], b[5:4] == 2'b01 && on[3],
               b[1:0] == 2'b10 && on[2], b[1:0] == 2'b01 && on[2],
               a[4] && on[1], a[0] && on[0]};
  endfunction

  function automatic logic [3:0] exp_chan(input logic [7:0] a, input logic [7:0] b,
                                          input logic [5:0] p);
    exp_chan = {(b[5:4] == 2'b01 && p[4]) || (b[5:4] == 2'b10 && p[5]),
                (b[1:0] == 2'b01 && p[2]) || (b[1:0] == 2'b10 && p[3]),
                a[4] && p[1], a[0] && p[0]};
  endfunction

  // ==========================================
  // main sequence
  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i} = 3'b100;
    reg_addr_i       = 16'h0000;
    reg_wdata_i      = 8'h00;
    tmr_out_i        = 4'h0;
    tmr_drive_mode_i = 4'hf;
    pin_i            = 6'h00;
    n_fail           = 0;
    checked          = 0;
    void'($urandom(32'hf72fb461));
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk_reg(`TPR_ROUTE0_ADDR, 8'h00);
    chk_reg(`TPR_ROUTE1_ADDR, 8'h00);
    chk_reg(`TPR_OER_ADDR, 8'h0f);
    chk_reg(16'h0190, 8'h00);
    chk_reg(`TPR_ICLR_ADDR, 8'h00);
    // random routes and disables, code 11 left out as software must
    for (int k = 0; k < 16; k++) begin
      r0  = 8'($urandom);
      r1  = 8'($urandom);
      dis = 4'($urandom);
      md  = 8'($urandom);
      if (r1[1:0] == 2'b11) r1[1:0] = 2'b01;
      if (r1[5:4] == 2'b11) r1[5:4] = 2'b10;
      wr(`TPR_ROUTE0_ADDR, r0);
      wr(`TPR_ROUTE1_ADDR, r1);
      wr(`TPR_OER_ADDR, {4'h0, dis});
      tmr_out_i        <= 4'($urandom);
      tmr_drive_mode_i <= md[3:0];
      pin_i            <= 6'($urandom);
      wait_n(2);
      es = exp_sel(r0, r1, dis, md[3:0]);
      chk(8'(pin_tmr_sel_o), 8'(es));
      chk(8'(pin_tmr_dat_o), 8'(es & {tmr_out_i[3], tmr_out_i[3], tmr_out_i[2],
                                      tmr_out_i[2], tmr_out_i[1], tmr_out_i[0]}));
      chk(8'(chan_in_o), 8'(exp_chan(r0, r1, pin_i)));
      chk_reg(`TPR_ROUTE0_ADDR, r0 & 8'h11);
      chk_reg(`TPR_ROUTE1_ADDR, r1 & 8'h33);
    end
    // edge flag in falling, rising and both-edge modes, cutoff disarmed
    tmr_drive_mode_i <= 4'hf;
    wr(`TPR_OER_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      r0 = (i == 0) ? 8'h01 : (i == 1) ? 8'h05 : 8'h03;
      wr(`TPR_IRQ0C_ADDR, r0);
      u_tpr_fault_src.fall();
      wait_n(3);
      chk(8'(ext_irq0_req_o), 8'(i != 1));
      wr(`TPR_IRQ0C_ADDR, r0);
      u_tpr_fault_src.rise();
      wait_n(3);
      chk(8'(ext_irq0_req_o), 8'(i != 0));
    end
    chk_reg(`TPR_OER_ADDR, 8'h00);
    // cutoff: routes first, falling edge, filter off, arm last
    // the port block parks freed pins low
    pin_i <= 6'h00;
    wr(`TPR_ROUTE0_ADDR, 8'h11);
    wr(`TPR_ROUTE1_ADDR, 8'h11);
    wr(`TPR_IRQ0C_ADDR, 8'h01);
    wr(`TPR_ICLR_ADDR, 8'h03);
    wr(`TPR_IEN_ADDR, 8'h02);
    wr(`TPR_OER_ADDR, 8'h80);
    wait_n(2);
    chk(8'(pin_tmr_sel_o), 8'h17);
    chk(8'(irq_o), 8'h00);
    u_tpr_fault_src.fall();
    wait_n(2);
    chk(8'(pin_tmr_sel_o), 8'h00);
    wait_n(1);
    chk(8'(irq_o), 8'h01);
    chk_reg(`TPR_OER_ADDR, 8'h8f);
    chk_reg(`TPR_ISTAT_ADDR, 8'h03);
    // re-enable refused while the pin stays low
    wr(`TPR_OER_ADDR, 8'h80);
    chk_reg(`TPR_OER_ADDR, 8'h8f);
    u_tpr_fault_src.rise();
    wr(`TPR_OER_ADDR, 8'h80);
    wait_n(2);
    chk(8'(pin_tmr_sel_o), 8'h17);
    wr(`TPR_ICLR_ADDR, 8'h03);
    wait_n(2);
    chk(8'(irq_o), 8'h00);
    // masked event: status set, interrupt stays low
    wr(`TPR_IEN_ADDR, 8'h00);
    u_tpr_fault_src.fall();
    wait_n(4);
    chk(8'(irq_o), 8'h00);
    chk(8'(pin_tmr_sel_o), 8'h00);
    chk_reg(`TPR_ISTAT_ADDR, 8'h03);
    u_tpr_fault_src.rise();
    wait_n(2);
    // filtered cutoff: the low level counts only after three equal samples
    wr(`TPR_OER_ADDR, 8'h80);
    wr(`TPR_IRQ0C_ADDR, 8'h11);
    u_tpr_fault_src.fall();
    wait_n(1);
    chk(8'(pin_tmr_sel_o), 8'h17);
    wait_n(5);
    chk(8'(pin_tmr_sel_o), 8'h00);
    chk(8'(ext_irq0_req_o), 8'h01);
    u_tpr_fault_src.rise();
    wait_n(2);
    close_out();
  end
endmodule // tpr_top_tb

`default_nettype wire

// ===== rtl/tpr_filt.sv
// digital noise filter for the external interrupt 0 pin
// assumes the pin is synchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "tpr_regs.svh"

module tpr_filt
  import tpr_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              pin_i,
  input  wire tpr_pkg::tpr_filt_t sel_i,
  output logic                   lvl_o
);
  logic [4:0] div_r,  div_nxt;
  logic [2:0] smp_r,  smp_nxt;
  logic       filt_r, filt_nxt;
  logic [4:0] period;
  logic       tick;

  // ==========================================
  // sample divider and majority-free agreement check
  always_comb begin
    case (sel_i)
      TPR_FILT_F8:  period = `TPR_FILT_DIV8;
      TPR_FILT_F32: period = `TPR_FILT_DIV32;
      default:      period = `TPR_FILT_DIV1;
    endcase
    tick     = (div_r >= period);
    div_nxt  = tick ? 5'h00 : div_r + 5'h01;
    smp_nxt  = tick ? {smp_r[1:0], pin_i} : smp_r;
    filt_nxt = filt_r;
    if (smp_r == 3'b111) begin
      filt_nxt = 1'b1;
    end else if (smp_r == 3'b000) begin
      filt_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      div_r  <= 5'h00;
      smp_r  <= 3'h7;
      filt_r <= 1'b1;
    end else begin
      div_r  <= div_nxt;
      smp_r  <= smp_nxt;
      filt_r <= filt_nxt;
    end
  end

  // unfiltered path keeps the cutoff within two cycles
  assign lvl_o = (sel_i == TPR_FILT_NONE) ? pin_i : filt_r;
endmodule // tpr_filt

`default_nettype wire

// ===== rtl/tpr_irq.sv
// sticky event status, write-one clear, enable and level interrupt
// assumes one-cycle event pulses and one-cycle write strobes
`timescale 1ns/1ps
`default_nettype none

module tpr_irq (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] ev_i,
  input  wire logic       clr_wr_i,
  input  wire logic       en_wr_i,
  input  wire logic [1:0] wdata_i,
  output logic      [1:0] status_o,
  output logic      [1:0] enable_o,
  output logic            irq_o
);
  logic [1:0] stat_nxt;
  logic [1:0] en_nxt;
  logic       irq_nxt;

  always_comb begin
    // an event in the clearing cycle survives
    stat_nxt = (status_o & ~({2{clr_wr_i}} & wdata_i)) | ev_i;
    en_nxt   = en_wr_i ? wdata_i : enable_o;
    irq_nxt  = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      status_o <= 2'h0;
      enable_o <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      status_o <= stat_nxt;
      enable_o <= en_nxt;
      irq_o    <= irq_nxt;
    end
  end

  sticky_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (status_o[0] && !clr_wr_i) |=> status_o[0])
    else $error("status bit dropped without a clear");
endmodule // tpr_irq

`default_nettype wire

// ===== rtl/tpr_pkg.sv
// types shared by the pin route and cutoff block
// assumes nothing of its surroundings
package tpr_pkg;
  typedef enum logic [1:0] {
    TPR_ROUTE_NONE = 2'b00,
    TPR_ROUTE_PIN1 = 2'b01,
    TPR_ROUTE_PIN2 = 2'b10,
    TPR_ROUTE_BAD  = 2'b11
  } tpr_route_t;

  typedef enum logic [1:0] {
    TPR_FILT_NONE = 2'b00,
    TPR_FILT_F1   = 2'b01,
    TPR_FILT_F8   = 2'b10,
    TPR_FILT_F32  = 2'b11
  } tpr_filt_t;
endpackage

// ===== rtl/tpr_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a byte-wide register port addressed by printed offsets
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH

// ==========================================
// offsets
`define TPR_ROUTE0_ADDR   16'h0182
`define TPR_ROUTE1_ADDR   16'h0183
`define TPR_OER_ADDR      16'h0184
`define TPR_IRQ0C_ADDR    16'h0185
`define TPR_ISTAT_ADDR    16'h0186
`define TPR_ICLR_ADDR     16'h0187
`define TPR_IEN_ADDR      16'h0188

// ==========================================
// fields
`define TPR_ROUTE0_MASK   8'h11
`define TPR_ROUTE1_MASK   8'h33
`define TPR_CHA_BIT       0
`define TPR_CHB_BIT       4
`define TPR_CHC_LSB       0
`define TPR_CHD_LSB       4
`define TPR_OER_MASK      8'h8f
`define TPR_ARM_BIT       7
`define TPR_IRQ0C_MASK    8'hb7
`define TPR_IEN_BIT       0
`define TPR_BOTH_BIT      1
`define TPR_POL_BIT       2
`define TPR_FILT_LSB      4
`define TPR_REQ_BIT       7
`define TPR_EV_REQ        0
`define TPR_EV_CUT        1

// ==========================================
// reset values
`define TPR_ROUTE_RST     8'h00
`define TPR_OER_RST       8'h0f
`define TPR_IRQ0C_RST     8'h00

// ==========================================
// filter sample periods in clock cycles minus one (compare limits: 0, 7 and 31 give 1, 8 and 32)
`define TPR_FILT_DIV1     5'h00
`define TPR_FILT_DIV8     5'h07
`define TPR_FILT_DIV32    5'h1f
`define TPR_FILT_SAMPLES  3

`endif

// ===== rtl/tpr_top.sv
// timer pin routing and forced output cutoff from the interrupt 0 pin
// assumes a timer core supplying channel outputs and a port block
// that owns every pin whose select output is low
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpr_regs.svh"

// Function
// - channel A route bit: 0 pin unused, 1 pin assigned.
// - channel C field: 00 unused, 01 first pin, 10 second; never 11.
// - cutoff only affects pins in output compare, PWM or dual-PWM mode.
// - disable bit 0 lets timer drive pin; 1 makes it general I/O.
// - armed and interrupt 0 pin low sets all four disable bits.
// - pins return to general I/O within one to two clocks with the filter off.
// - request flag sets on each matching edge, apart from cutoff.
// - unassigned route bits read zero; software writes zero there.
module tpr_top
  import tpr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [3:0]  tmr_out_i,
  input  wire logic [3:0]  tmr_drive_mode_i,
  input  wire logic [5:0]  pin_i,
  input  wire logic        ext_irq0_n_i,
  output logic      [5:0]  pin_tmr_sel_o,
  output logic      [5:0]  pin_tmr_dat_o,
  output logic      [3:0]  chan_in_o,
  output logic             ext_irq0_req_o,
  output logic             irq_o
);
  import tpr_pkg::*;

  // ==========================================
  // functions
  function automatic logic route_hit(input logic [1:0] code, input tpr_route_t want);
    // code 11 owns no pin, so a forbidden write never drives two pins
    route_hit = (code == want);
  endfunction

  // pin order: A, B, C first, C second, D first, D second
  function automatic logic [5:0] per_pin(input logic [3:0] ch);
    per_pin = {ch[3], ch[3], ch[2], ch[2], ch[1], ch[0]};
  endfunction

  // ==========================================
  // register state
  logic [7:0] route0_r, route0_nxt;
  logic [7:0] route1_r, route1_nxt;
  logic [7:0] oer_r,    oer_nxt;
  logic [7:0] irq0c_r,  irq0c_nxt;
  logic [7:0] rdata_nxt;
  logic [1:0] istat;
  logic [1:0] ien;
  logic       wr_route0;
  logic       wr_route1;
  logic       wr_oer;
  logic       wr_irq0c;
  logic       wr_iclr;
  logic       wr_ien;

  assign wr_route0 = reg_wr_i && (reg_addr_i == `TPR_ROUTE0_ADDR);
  assign wr_route1 = reg_wr_i && (reg_addr_i == `TPR_ROUTE1_ADDR);
  assign wr_oer    = reg_wr_i && (reg_addr_i == `TPR_OER_ADDR);
  assign wr_irq0c  = reg_wr_i && (reg_addr_i == `TPR_IRQ0C_ADDR);
  assign wr_iclr   = reg_wr_i && (reg_addr_i == `TPR_ICLR_ADDR);
  assign wr_ien    = reg_wr_i && (reg_addr_i == `TPR_IEN_ADDR);

  // ==========================================
  // interrupt 0 input path
  logic       irq0_lvl;
  logic       prev_lvl_r, prev_lvl_nxt;
  logic       edge_hit;
  logic       cut_now;
  tpr_filt_t  filt_sel;

  assign filt_sel = tpr_filt_t'(irq0c_r[`TPR_FILT_LSB +: 2]);

  tpr_filt u_filt (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (ext_irq0_n_i),
    .sel_i     (filt_sel),
    .lvl_o     (irq0_lvl)
  );

  always_comb begin
    prev_lvl_nxt = irq0_lvl;
    edge_hit     = 1'b0;
    if (irq0c_r[`TPR_IEN_BIT]) begin
      if (irq0c_r[`TPR_BOTH_BIT]) begin
        edge_hit = (irq0_lvl != prev_lvl_r);
      end else if (irq0c_r[`TPR_POL_BIT]) begin
        edge_hit = irq0_lvl && !prev_lvl_r;
      end else begin
        edge_hit = !irq0_lvl && prev_lvl_r;
      end
    end
    // a held low level keeps cutting, even against a software re-enable
    cut_now = oer_r[`TPR_ARM_BIT] && !irq0_lvl;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prev_lvl_r <= 1'b1;
    end else begin
      prev_lvl_r <= prev_lvl_nxt;
    end
  end

  // ==========================================
  // register next values
  always_comb begin
    route0_nxt = wr_route0 ? (reg_wdata_i & `TPR_ROUTE0_MASK) : route0_r;
    route1_nxt = wr_route1 ? (reg_wdata_i & `TPR_ROUTE1_MASK) : route1_r;
    oer_nxt    = wr_oer ? (reg_wdata_i & `TPR_OER_MASK) : oer_r;
    if (cut_now) begin
      oer_nxt[3:0] = 4'hf;
    end
    irq0c_nxt = irq0c_r;
    if (wr_irq0c) begin
      irq0c_nxt = (reg_wdata_i & `TPR_IRQ0C_MASK) | (irq0c_r & 8'h80);
      // the request flag clears only by writing zero to it
      irq0c_nxt[`TPR_REQ_BIT] = irq0c_r[`TPR_REQ_BIT] & reg_wdata_i[`TPR_REQ_BIT];
    end
    if (edge_hit) begin
      irq0c_nxt[`TPR_REQ_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      route0_r <= `TPR_ROUTE_RST;
      route1_r <= `TPR_ROUTE_RST;
      oer_r    <= `TPR_OER_RST;
      irq0c_r  <= `TPR_IRQ0C_RST;
    end else begin
      route0_r <= route0_nxt;
      route1_r <= route1_nxt;
      oer_r    <= oer_nxt;
      irq0c_r  <= irq0c_nxt;
    end
  end

  // ==========================================
  // pin ownership, built from next values so the cutoff lands at once
  logic [5:0] routed;
  logic [5:0] sel_nxt;
  logic [5:0] dat_nxt;
  logic [3:0] cin_nxt;
  logic       req_nxt;

  always_comb begin
    routed[0] = route0_nxt[`TPR_CHA_BIT];
    routed[1] = route0_nxt[`TPR_CHB_BIT];
    routed[2] = route_hit(route1_nxt[`TPR_CHC_LSB +: 2], TPR_ROUTE_PIN1);
    routed[3] = route_hit(route1_nxt[`TPR_CHC_LSB +: 2], TPR_ROUTE_PIN2);
    routed[4] = route_hit(route1_nxt[`TPR_CHD_LSB +: 2], TPR_ROUTE_PIN1);
    routed[5] = route_hit(route1_nxt[`TPR_CHD_LSB +: 2], TPR_ROUTE_PIN2);
    // only output-mode channels hand their pin to the timer
    sel_nxt = routed & per_pin(tmr_drive_mode_i)
            & ~per_pin(oer_nxt[3:0]);
    dat_nxt = per_pin(tmr_out_i) & sel_nxt;
    cin_nxt[0] = routed[0] & pin_i[0];
    cin_nxt[1] = routed[1] & pin_i[1];
    cin_nxt[2] = (routed[2] & pin_i[2]) | (routed[3] & pin_i[3]);
    cin_nxt[3] = (routed[4] & pin_i[4]) | (routed[5] & pin_i[5]);
    req_nxt    = irq0c_nxt[`TPR_REQ_BIT];
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_tmr_sel_o  <= 6'h00;
      pin_tmr_dat_o  <= 6'h00;
      chan_in_o      <= 4'h0;
      ext_irq0_req_o <= 1'b0;
    end else begin
      pin_tmr_sel_o  <= sel_nxt;
      pin_tmr_dat_o  <= dat_nxt;
      chan_in_o      <= cin_nxt;
      ext_irq0_req_o <= req_nxt;
    end
  end

  // ==========================================
  // event interrupt
  tpr_irq u_irq (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .ev_i      ({cut_now, edge_hit}),
    .clr_wr_i  (wr_iclr),
    .en_wr_i   (wr_ien),
    .wdata_i   (reg_wdata_i[1:0]),
    .status_o  (istat),
    .enable_o  (ien),
    .irq_o     (irq_o)
  );

  // ==========================================
  // read port; unmapped and write-only addresses return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `TPR_ROUTE0_ADDR: rdata_nxt = route0_r & `TPR_ROUTE0_MASK;
        `TPR_ROUTE1_ADDR: rdata_nxt = route1_r & `TPR_ROUTE1_MASK;
        `TPR_OER_ADDR:    rdata_nxt = oer_r;
        `TPR_IRQ0C_ADDR:  rdata_nxt = irq0c_r;
        `TPR_ISTAT_ADDR:  rdata_nxt = {6'h00, istat};
        `TPR_IEN_ADDR:    rdata_nxt = {6'h00, ien};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence cut_start_s;
    oer_r[`TPR_ARM_BIT] && !ext_irq0_n_i && (filt_sel == TPR_FILT_NONE);
  endsequence

  sequence pins_free_s;
    pin_tmr_sel_o == 6'h00;
  endsequence

  route_a_pin_a: assert property (pin_tmr_sel_o[0] |-> route0_r[`TPR_CHA_BIT])
    else $error("channel A pin driven while unrouted");
  route_c_code_a: assert property (&route1_r[1:0] |-> !(|pin_tmr_sel_o[3:2]))
    else $error("channel C code 11 selected a pin");
  mode_gate_a: assert property ($rose(pin_tmr_sel_o[1]) |-> $past(tmr_drive_mode_i[1]))
    else $error("pin taken by a channel not in output mode");
  disable_gate_a: assert property (pin_tmr_sel_o[4] |-> !oer_r[3])
    else $error("disabled channel still drives its pin");
  cutoff_set_a: assert property (cut_now |=> (oer_r[3:0] == 4'hf))
    else $error("cutoff did not set every disable bit");
  cutoff_time_a: assert property (cut_start_s |-> ##[1:2] pins_free_s)
    else $error("pins not released within two clocks of cutoff");
  req_flag_a: assert property (edge_hit |=> ext_irq0_req_o && irq0c_r[`TPR_REQ_BIT])
    else $error("matching edge did not raise the request flag");
  unassigned_read_a: assert property (reg_rd_i && reg_addr_i == `TPR_ROUTE1_ADDR
    |=> (reg_rdata_o & 8'hcc) == 8'h00)
    else $error("unassigned route bits read non-zero");
endmodule // tpr_top

`default_nettype wire
